/* File: verification/lfct_node_model.sv */
// far lin node and bus wire: wired-and with recessive pull-up
// assumes the bench says when our node drives and when the far node shorts
`timescale 1ns/1ps
module lfct_node_model (
   input wire logic level_in,
   input wire logic drive_in,
   input wire logic hold_low_in,
   output logic bus_out
);
   // released bus goes recessive, dominant always wins
   assign bus_out = (drive_in ? level_in : 1'b1) & ~hold_low_in;
endmodule : lfct_node_model

/* File: verification/lfct_top_asserts.sv */
// port checker for the frame supervision block
// assumes binding into lfct_top, one clock domain
`timescale 1ns/1ps
module lfct_top_check
   import lfct_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic bus_receive_pin_in,
   input wire lfct_header_t header_in,
   input wire lfct_txbit_t tx_bit_in,
   input wire logic response_done_in,
   input wire logic synch_break_in,
   input wire logic checkbyte_send_out,
   input wire logic abort_tx_out,
   input wire logic ext_active_out,
   input wire logic frame_valid_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence send_cmd;
      wr_in && addr_in == 8'h04 && wdata_in[16];
   endsequence
   sequence stop_cmd;
      wr_in && addr_in == 8'h00 && wdata_in[13];
   endsequence
   send_pulse_a: assert property (send_cmd |=> checkbyte_send_out)
      else $error("checkbyte send missing");
   send_cause_a: assert property (checkbyte_send_out |->
      $past(wr_in && addr_in == 8'h04 && wdata_in[16]))
      else $error("checkbyte send without command");
   ext_cause_a: assert property ($rose(ext_active_out) |->
      $past(header_in.valid && header_in.id[5:0] == 6'h3e))
      else $error("extended frame without id 3e");
   ext_stop_a: assert property (stop_cmd |=> !ext_active_out)
      else $error("extended frame not stopped");
   ext_hold_a: assert property (ext_active_out && !header_in.valid &&
      !(wr_in && addr_in == 8'h00 && wdata_in[13]) |=> ext_active_out)
      else $error("extended frame dropped");
   bit_err_a: assert property (tx_bit_in.strobe &&
      tx_bit_in.level != bus_receive_pin_in |=> abort_tx_out)
      else $error("readback mismatch not aborted");
   abort_hold_a: assert property (abort_tx_out && !header_in.valid &&
      !synch_break_in |=> abort_tx_out)
      else $error("abort released early");
   fv_cause_a: assert property (frame_valid_out |->
      $past(response_done_in))
      else $error("frame valid without response end");
endmodule : lfct_top_check
bind lfct_top lfct_top_check u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
   .bus_receive_pin_in(bus_receive_pin_in), .header_in(header_in),
   .tx_bit_in(tx_bit_in), .response_done_in(response_done_in),
   .synch_break_in(synch_break_in), .checkbyte_send_out(checkbyte_send_out),
   .abort_tx_out(abort_tx_out), .ext_active_out(ext_active_out),
   .frame_valid_out(frame_valid_out));

/* File: verification/lin_frame_check_timeout_bench.sv */
// self-checking bench of the frame supervision block
// assumes lfct_node_model stands for the far node on the bus
`timescale 1ns/1ps
module lin_frame_check_timeout_bench
   import lfct_pkg::*;
;
   typedef struct packed {
      logic [7:0] id;
      logic ct;
      logic [7:0] d;
      logic [7:0] e;
   } lfct_row_t;
   lfct_row_t rows [5] = '{'{8'h05, 1'b1, 8'h10, 8'hea},
      '{8'h05, 1'b0, 8'h10, 8'hef}, '{8'h3c, 1'b1, 8'h10, 8'hef},
      '{8'h3b, 1'b1, 8'h10, 8'hb4}, '{8'h3b, 1'b1, 8'hf0, 8'hd3}};
   logic clk_in = 0, rst_n_in = 0, wr = 0, rd = 0, role = 1, rdone = 0;
   logic sbrk = 0, drive = 0, hold = 0, pin;
   logic [7:0] addr = 0, cb;
   logic [31:0] wdata = 0, rdata, v;
   lfct_header_t hdr = '0;
   lfct_byte_t rxb = '0, txb = '0;
   lfct_txbit_t tbit = '0;
   logic send, abort, ext, idv, fv, irq;
   int n_mismatch = 0, samples_checked = 0;
   int t;
   always #12.5 clk_in = ~clk_in;
   lfct_node_model u_node (.level_in(tbit.level), .drive_in(drive),
      .hold_low_in(hold), .bus_out(pin));
   lfct_top #(.IDLE_CYCLES(64)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .bus_receive_pin_in(pin), .header_in(hdr),
      .rx_byte_in(rxb), .tx_byte_in(txb), .tx_bit_in(tbit),
      .tx_role_in(role), .response_done_in(rdone), .synch_break_in(sbrk),
      .checkbyte_out(cb), .checkbyte_send_out(send), .abort_tx_out(abort),
      .ext_active_out(ext), .id_valid_out(idv), .frame_valid_out(fv),
      .irq_out(irq));
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc
   task wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in) begin wr <= 1; addr <= a; wdata <= d; end
      @(posedge clk_in) wr <= 0;
      #1;
   endtask : wreg
   task flag(input int b, input logic e);
      @(posedge clk_in) begin rd <= 1; addr <= 8'h0c; end
      @(posedge clk_in) rd <= 0;
      #1 chk("flag", {31'h0, e}, {31'h0, rdata[b]});
   endtask : flag
   task hd(input logic [7:0] id, input logic m);
      @(posedge clk_in) hdr <= '{1'b1, id, m};
      @(posedge clk_in) hdr.valid <= 0;
      #1;
   endtask : hd
   task by(input logic tx, input logic [7:0] d);
      @(posedge clk_in) if (tx) txb <= '{1'b1, d}; else rxb <= '{1'b1, d};
      @(posedge clk_in) begin txb.valid <= 0; rxb.valid <= 0; end
   endtask : by
   task tb(input logic hg);
      @(posedge clk_in) tbit <= '{1'b1, 1'b1, hg};
      @(posedge clk_in) tbit.strobe <= 0;
      #1;
   endtask : tb
   task end_of_test;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20000) @(posedge clk_in);
      n_mismatch++;
      end_of_test;
   end
   initial begin
      cyc(2);
      #1 chk("rst", 0, {rdata[25:0], send, abort, ext, idv, fv, irq});
      cyc(1);
      rst_n_in <= 1;
      @(posedge clk_in) begin rd <= 1; addr <= 8'h14; end
      @(posedge clk_in) addr <= 8'h04;
      #1 chk("bitper", 32'h0000_07d0, rdata);
      @(posedge clk_in) rd <= 0;
      #1 chk("unmapped", 0, rdata);
      wreg(8'h14, 32'h2);
      foreach (rows[i]) begin
         wreg(8'h00, {19'h0, rows[i].ct, 12'h0});
         hd(rows[i].id, 0);
         by(1, rows[i].d);
         wreg(8'h04, 32'h0001_0000);
         chk("send", 1, send);
         chk("checkbyte", rows[i].e, cb);
      end
      for (int i = 0; i < 3; i++) begin
         t = (i == 0) ? 77 : (i == 1) ? 175 : 119;
         wreg(8'h00, {31'h0, i == 2});
         wreg(8'h08, {13'h0, i == 1 ? 3'h7 : 3'h0, 16'h0});
         wreg(8'h0c, 32'hff);
         hd((i == 2) ? 8'h20 : 8'h10, 0);
         cyc(t * 2 - 6);
         flag(4, 0);
         cyc(12);
         flag(4, 1);
      end
      wreg(8'h0c, 32'hff);
      hd(8'h3e, 1);
      chk("ext", 1, ext);
      flag(6, 1);
      cyc(400);
      flag(4, 0);
      role <= 0;
      by(0, 8'h10);
      by(0, 8'hef);
      wreg(8'h04, 32'h0002_0000);
      flag(3, 0);
      by(0, 8'h01);
      wreg(8'h04, 32'h0002_0000);
      flag(3, 1);
      wreg(8'h00, 32'h2000);
      chk("ext stop", 0, ext);
      hd(8'h3f, 0);
      chk("ext id 3f", 0, ext);
      for (int i = 0; i < 2; i++) begin
         wreg(8'h0c, 32'hff);
         hd(8'h05, 0);
         by(0, 8'h10);
         by(0, i ? 8'hee : 8'hef);
         @(posedge clk_in) rdone <= 1;
         @(posedge clk_in) rdone <= 0;
         #1 chk("frame valid", i ? 0 : 1, fv);
         flag(3, i);
      end
      wreg(8'h00, 32'h4);
      hd(8'h50, 0);
      chk("id valid", 1, idv);
      hd(8'h90, 0);
      chk("id bad", 0, idv);
      flag(2, 1);
      wreg(8'h0c, 32'hff);
      drive <= 1;
      tb(0);
      flag(0, 0);
      hold <= 1;
      tb(0);
      chk("abort", 1, abort);
      flag(0, 1);
      @(posedge clk_in) sbrk <= 1;
      @(posedge clk_in) sbrk <= 0;
      #1 chk("abort end", 0, abort);
      tb(1);
      flag(1, 1);
      wreg(8'h10, 32'h1);
      cyc(1);
      #1 chk("irq on", 1, irq);
      wreg(8'h0c, 32'hff);
      chk("irq off", 0, irq);
      repeat (2) begin
         cyc(30);
         hold <= ~hold;
      end
      flag(5, 0);
      cyc(70);
      flag(5, 1);
      end_of_test;
   end
endmodule : lin_frame_check_timeout_bench

/* File: verilog/lfct_params.svh */
// constants of the lin frame check and timeout block
// assumes a 40 mhz module clock and byte-addressed register port
`ifndef LFCT_PARAMS_SVH
`define LFCT_PARAMS_SVH
`define LFCT_CLK_MHZ 40
`define LFCT_OFF_GCR1 8'h00
`define LFCT_OFF_GCR2 8'h04
`define LFCT_OFF_FORMAT 8'h08
`define LFCT_OFF_FLAGS 8'h0c
`define LFCT_OFF_ENABLE 8'h10
`define LFCT_OFF_BITPER 8'h14
`define LFCT_OFF_IDSTAT 8'h18
`define LFCT_GCR1_COMM 0
`define LFCT_GCR1_PARITY 2
`define LFCT_GCR1_CHECKSUM_TYPE_SELECT 12
`define LFCT_GCR1_STOPEXT 13
`define LFCT_GCR2_SENDCB 16
`define LFCT_GCR2_CMPCB 17
`define LFCT_FMT_LEN_LO 16
`define LFCT_FMT_LEN_HI 18
`define LFCT_FL_BIT 0
`define LFCT_FL_PBE 1
`define LFCT_FL_PAR 2
`define LFCT_FL_CKS 3
`define LFCT_FL_NRE 4
`define LFCT_FL_IDLE 5
`define LFCT_FL_ID 6
`define LFCT_FL_EXT 7
`define LFCT_GCR1_RST 32'h0000_0000
`define LFCT_FORMAT_RST 32'h0000_0000
`define LFCT_ENABLE_RST 8'h00
`define LFCT_BITPER_RST 16'h07d0
`define LFCT_ID_EXT 6'h3e
`define LFCT_ID_RSV 6'h3f
`define LFCT_ID_CLASSIC_MIN 6'h3c
`define LFCT_CKS_GOOD 8'hff
`define LFCT_HDR_MIN_BITS 16'd44
`define LFCT_DATA_BITS 16'd10
`define LFCT_MAX_NUM 16'd14
`define LFCT_MAX_DEN 16'd10
`define LFCT_IDLE_TIME_MS 4000
`define LFCT_IDLE_CYCLES (`LFCT_IDLE_TIME_MS * `LFCT_CLK_MHZ * 1000)
`endif

/* File: verilog/lfct_pkg.sv */
// types of the lin frame check and timeout block
// assumes lfct_params.svh supplies all numeric constants
package lfct_pkg;
   // one byte event from the serial engine
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } lfct_byte_t;
   // end of header with received identifier byte and filter result
   typedef struct packed {
      logic valid;
      logic [7:0] id;
      logic match;
   } lfct_header_t;
   // one transmitted bit and the level that was driven
   typedef struct packed {
      logic strobe;
      logic level;
      logic header_gen;
   } lfct_txbit_t;
endpackage : lfct_pkg

/* File: verilog/lfct_top.sv */
// lin frame supervision: checksum, parity, bit monitor, timeouts
// assumes a serial engine that reports headers, bytes and driven bits
// Function
// - header id 0x3e starts extended frame
// - extended frame stopped by control one bit 13
// - ids 62 and 63 get unlimited length
// - any header with match and no parity error raises id flag
// - control two bit 16 sends running checkbyte
// - control two bit 17 forces checksum compare
// - ids 60 to 63 always classic checksum
// - ids 0 to 59 follow checksum type bit
// - no complete frame in time sets no-response
// - minimum frame time is 44 plus 10n
// - maximum frame time is (min plus one)*1.4
// - n from id length bits or length field
// - no no-response error for ids 0x3e, 0x3f
// - bus idle flag after 4 s without edges
// - each error own flag, valid if none
// - readback differs from driven bit: bit error
// - abort transmission right after bit error
// - header mismatch sets physical bus error
// - p0 and p1 computed from identifier bits
// - parity mismatch flags error, id invalid
// - receive check: carry-around sum equals 0xff
// - transmit checkbyte is inverted carry-around sum
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "lfct_params.svh"
module lfct_top
   import lfct_pkg::*;
#(
   parameter int IDLE_CYCLES = `LFCT_IDLE_CYCLES,
   parameter int IDLE_W = 28
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire logic bus_receive_pin_in,
   input wire lfct_header_t header_in,
   input wire lfct_byte_t rx_byte_in,
   input wire lfct_byte_t tx_byte_in,
   input wire lfct_txbit_t tx_bit_in,
   input wire logic tx_role_in,
   input wire logic response_done_in,
   input wire logic synch_break_in,
   output logic [7:0] checkbyte_out,
   output logic checkbyte_send_out,
   output logic abort_tx_out,
   output logic ext_active_out,
   output logic id_valid_out,
   output logic frame_valid_out,
   output logic irq_out
);

   generate
      if (IDLE_CYCLES < 2 || IDLE_CYCLES >= (2 ** IDLE_W) || IDLE_W > 31)
      begin : bad_cfg
         $error("lfct_top: idle count does not fit its counter");
      end
      if (`LFCT_BITPER_RST == 16'h0000) begin : bad_bitper
         $error("lfct_top: bit period reset value must not be zero");
      end
      if (`LFCT_MAX_NUM <= `LFCT_MAX_DEN) begin : bad_ratio
         $error("lfct_top: frame time factor must exceed one");
      end
   endgenerate

   typedef struct packed {
      logic [31:0] gcr1;
      logic [31:0] format;
      logic [7:0] enable;
      logic [15:0] bitper;
      logic [6:0] flags;
      logic [7:0] cur_id;
      logic ext_active;
      logic [7:0] sum;
      logic nre_armed;
      logic [15:0] tick_cnt;
      logic [15:0] bit_cnt;
      logic [15:0] frame_max;
      logic [IDLE_W-1:0] idle_cnt;
      logic pin_q;
      logic err_seen;
      logic abort;
      logic [7:0] checkbyte;
      logic cb_send;
      logic irq;
      logic frame_valid;
      logic id_valid;
      logic [31:0] rdata;
   } lfct_state_t;

   lfct_state_t s;
   lfct_state_t next_s;

   // carry-around addition, carry folded back into lsb
   function automatic logic [7:0] eac_add(input logic [7:0] a,
                                          input logic [7:0] b);
      logic [8:0] t;
      t = {1'b0, a} + {1'b0, b};
      return t[7:0] + {7'h00, t[8]};
   endfunction : eac_add

   // longest frame in bit times for n data bytes
   function automatic logic [15:0] frame_max_bits(input logic [3:0] n);
      logic [15:0] fmin;
      fmin = `LFCT_HDR_MIN_BITS + `LFCT_DATA_BITS * {12'h000, n};
      return ((fmin + 16'd1) * `LFCT_MAX_NUM) / `LFCT_MAX_DEN;
   endfunction : frame_max_bits

   // checksum seed: zero for classic, id byte for enhanced
   function automatic logic [7:0] seed_of(input logic cls,
                                          input logic [7:0] id);
      return cls ? 8'h00 : id;
   endfunction : seed_of

   logic [5:0] hid;
   logic par_ok;
   logic classic;
   logic [3:0] nbytes;
   logic [7:0] add_byte;
   logic add_en;
   logic [6:0] set_fl;
   logic [6:0] clr_fl;
   logic tick;
   logic classic_cur;
   logic resp_ok;
   logic bit_bad;
   logic pin_edge;

   always_comb begin
      hid = header_in.id[5:0];
      // p0 even over id bits 0,1,2,4, p1 odd over id bits 1,3,4,5
      par_ok = (header_in.id[6] == (hid[0] ^ hid[1] ^ hid[2] ^ hid[4])) &&
         (header_in.id[7] == ~(hid[1] ^ hid[3] ^ hid[4] ^ hid[5]));
      // reserved ids forced classic, others follow type bit
      classic = (hid >= `LFCT_ID_CLASSIC_MIN) ||
         !s.gcr1[`LFCT_GCR1_CHECKSUM_TYPE_SELECT];
      // byte count from id length bits or length field
      if (s.gcr1[`LFCT_GCR1_COMM]) begin
         case (hid[5:4])
            2'b10: nbytes = 4'd4;
            2'b11: nbytes = 4'd8;
            default: nbytes = 4'd2;
         endcase
      end else begin
         nbytes = {1'b0, s.format[`LFCT_FMT_LEN_HI:`LFCT_FMT_LEN_LO]} + 4'd1;
      end
      add_byte = tx_role_in ? tx_byte_in.data : rx_byte_in.data;
      add_en = tx_role_in ? tx_byte_in.valid : rx_byte_in.valid;
      tick = (s.tick_cnt == 16'h0000);
      // checksum type of the frame in progress, for reseeding
      classic_cur = (s.cur_id[5:0] >= `LFCT_ID_CLASSIC_MIN) ||
         !s.gcr1[`LFCT_GCR1_CHECKSUM_TYPE_SELECT];
      // receiver accepts only a sum of all ones
      resp_ok = tx_role_in || (s.sum == `LFCT_CKS_GOOD);
      // readback differs from the level driven
      bit_bad = tx_bit_in.strobe &&
         (tx_bit_in.level != bus_receive_pin_in);
      // any recessive/dominant transition
      pin_edge = (bus_receive_pin_in != s.pin_q);
   end

   always_comb begin
      next_s = s;
      set_fl = 7'h00;
      clr_fl = 7'h00;
      next_s.cb_send = 1'b0;
      next_s.frame_valid = 1'b0;
      next_s.rdata = 32'h0000_0000;
      next_s.pin_q = bus_receive_pin_in;

      // bit-time prescaler
      if (tick) begin
         next_s.tick_cnt = s.bitper - 16'd1;
      end else begin
         next_s.tick_cnt = s.tick_cnt - 16'd1;
      end

      // bus idle watch
      if (pin_edge) begin
         next_s.idle_cnt = '0;
      end else if (s.idle_cnt == IDLE_CYCLES[IDLE_W-1:0] - 1'b1) begin
         set_fl[`LFCT_FL_IDLE] = 1'b1;
      end else begin
         next_s.idle_cnt = s.idle_cnt + 1'b1;
      end

      // no-response timer in bit times
      if (s.nre_armed && tick) begin
         if (s.bit_cnt + 16'd1 >= s.frame_max) begin
            set_fl[`LFCT_FL_NRE] = 1'b1;
            next_s.err_seen = 1'b1;
            next_s.nre_armed = 1'b0;
         end else begin
            next_s.bit_cnt = s.bit_cnt + 16'd1;
         end
      end

      // running checksum over response bytes
      if (add_en) begin
         next_s.sum = eac_add(s.sum, add_byte);
      end

      // bit monitor on every driven bit
      if (bit_bad) begin
         if (tx_bit_in.header_gen) begin
            set_fl[`LFCT_FL_PBE] = 1'b1;
         end else begin
            set_fl[`LFCT_FL_BIT] = 1'b1;
         end
         next_s.abort = 1'b1;
         next_s.err_seen = 1'b1;
      end

      // response end: receiver checks the sum incl. checkbyte
      if (response_done_in) begin
         next_s.nre_armed = 1'b0;
         if (!resp_ok) begin
            set_fl[`LFCT_FL_CKS] = 1'b1;
         end else if (!s.err_seen) begin
            next_s.frame_valid = 1'b1;
         end
      end

      if (synch_break_in) begin
         next_s.nre_armed = 1'b0;
         next_s.bit_cnt = 16'h0000;
         next_s.err_seen = 1'b0;
         next_s.abort = 1'b0;
      end

      // header end: parity, id flag, extended frame, timer start
      if (header_in.valid) begin
         next_s.cur_id = header_in.id;
         next_s.abort = 1'b0;
         next_s.bit_cnt = 16'h0000;
         next_s.tick_cnt = s.bitper - 16'd1;
         next_s.frame_max = frame_max_bits(nbytes);
         next_s.sum = seed_of(classic, header_in.id);
         if (s.gcr1[`LFCT_GCR1_PARITY] && !par_ok) begin
            set_fl[`LFCT_FL_PAR] = 1'b1;
            next_s.err_seen = 1'b1;
            next_s.id_valid = 1'b0;
            next_s.nre_armed = 1'b0;
         end else begin
            next_s.err_seen = 1'b0;
            next_s.id_valid = 1'b1;
            if (header_in.match) begin
               set_fl[`LFCT_FL_ID] = 1'b1;
            end
            if (hid == `LFCT_ID_EXT) begin
               next_s.ext_active = 1'b1;
            end
            // arbitrary-length ids never time out
            next_s.nre_armed = (hid != `LFCT_ID_EXT) &&
               (hid != `LFCT_ID_RSV);
         end
      end

      // register writes
      if (wr_in) begin
         case (addr_in)
            `LFCT_OFF_GCR1: begin
               next_s.gcr1 = wdata_in;
               next_s.gcr1[`LFCT_GCR1_STOPEXT] = 1'b0;
               if (wdata_in[`LFCT_GCR1_STOPEXT]) begin
                  next_s.ext_active = 1'b0;
               end
            end
            `LFCT_OFF_GCR2: begin
               if (wdata_in[`LFCT_GCR2_SENDCB]) begin
                  next_s.checkbyte = ~s.sum;
                  next_s.cb_send = 1'b1;
                  next_s.sum = seed_of(classic_cur, s.cur_id);
               end else if (wdata_in[`LFCT_GCR2_CMPCB]) begin
                  if (s.sum != `LFCT_CKS_GOOD) begin
                     set_fl[`LFCT_FL_CKS] = 1'b1;
                  end
                  next_s.sum = seed_of(classic_cur, s.cur_id);
               end
            end
            `LFCT_OFF_FORMAT: next_s.format = wdata_in;
            `LFCT_OFF_FLAGS: clr_fl = wdata_in[6:0];
            `LFCT_OFF_ENABLE: next_s.enable = wdata_in[7:0];
            `LFCT_OFF_BITPER: begin
               if (wdata_in[15:0] != 16'h0000) begin
                  next_s.bitper = wdata_in[15:0];
               end
            end
            default: ;
         endcase
      end

      // sticky flags, a set beats a clear in the same cycle
      next_s.flags = (s.flags & ~clr_fl) | set_fl;
      if (set_fl[`LFCT_FL_CKS]) begin
         next_s.err_seen = 1'b1;
      end
      next_s.irq = |(next_s.flags & s.enable[6:0]);

      // register reads, data stand one cycle later
      if (rd_in) begin
         case (addr_in)
            `LFCT_OFF_GCR1: next_s.rdata = s.gcr1;
            `LFCT_OFF_FORMAT: next_s.rdata = s.format;
            `LFCT_OFF_FLAGS: next_s.rdata = {24'h000000, s.ext_active,
               s.flags};
            `LFCT_OFF_ENABLE: next_s.rdata = {24'h000000, s.enable};
            `LFCT_OFF_BITPER: next_s.rdata = {16'h0000, s.bitper};
            `LFCT_OFF_IDSTAT: next_s.rdata = {23'h000000, s.id_valid,
               s.cur_id};
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s <= '0;
         s.gcr1 <= `LFCT_GCR1_RST;
         s.format <= `LFCT_FORMAT_RST;
         s.enable <= `LFCT_ENABLE_RST;
         s.bitper <= `LFCT_BITPER_RST;
         s.pin_q <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign rdata_out = s.rdata;
   assign checkbyte_out = s.checkbyte;
   assign checkbyte_send_out = s.cb_send;
   assign abort_tx_out = s.abort;
   assign ext_active_out = s.ext_active;
   assign id_valid_out = s.id_valid;
   assign frame_valid_out = s.frame_valid;
   assign irq_out = s.irq;

endmodule : lfct_top
